// ---- rtl/rtxc_radio_tx_ctrl.sv ----
// Radio transmit control register bank with its transmit sequencer.
// Assumes a classic Wishbone master and a lock input synchronous to clk_i.
`timescale 1ns/1ps
module rtxc_radio_tx_ctrl #(
  parameter int unsigned ADR_W = 8,
  parameter int unsigned UNIT_CYCLES = rtxc_pkg::SETTLE_UNIT_CYCLES
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Radio side.
  input wire logic synth_lock_i,
  output logic synth_enable_o,
  output logic tx_mode_o,
  output logic upper_half_o,
  output logic amp_on_o
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  // All flip-flops of the block outside the settle timer in one record.
  typedef struct packed {
    logic [7:0] ctrl; // Transmit control fields.
    logic [7:0] code_width; // Chips-per-bit setting.
    logic [7:0] settle_count; // Settle time in units.
    rtxc_pkg::rtxc_state_t fsm; // Sequencer state.
    logic ack; // Bus acknowledge.
    logic [7:0] rdata; // Read data, low byte.
    logic upper_half; // Registered half-code choice.
    logic amp_on; // Registered amplifier enable.
  } rtxc_regs_t;

  rtxc_regs_t st_reg; // Registered state.
  rtxc_regs_t st_next; // Next state.
  logic timer_start; // Loads the settle timer.
  logic timer_done; // Settle time has passed.
  logic bus_req; // A bus cycle is pending.
  logic wr_fire; // Write takes effect this edge.
  logic [5:0] reg_idx; // Word index from the address.
  logic [7:0] status; // Live status byte.

  // Field views, named for readability.
  logic tx_on;
  logic half_sel;
  logic lock_bypass;
  logic amp_manual_mode;
  logic amp_manual_on;
  logic code_32;

  assign tx_on = st_reg.ctrl[rtxc_pkg::BIT_TX_ON];
  assign half_sel = st_reg.ctrl[rtxc_pkg::BIT_HALF_SEL];
  assign lock_bypass = st_reg.ctrl[rtxc_pkg::BIT_LOCK_BYPASS];
  assign amp_manual_mode = st_reg.ctrl[rtxc_pkg::BIT_AMP_MANUAL_MODE];
  assign amp_manual_on = st_reg.ctrl[rtxc_pkg::BIT_AMP_MANUAL_ON];
  assign code_32 = st_reg.code_width[rtxc_pkg::BIT_CODE_32];

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  // The low two address bits are ignored; every register is a whole word.
  assign reg_idx = adr_i[7:2];
  assign bus_req = cyc_i && stb_i;
  // The write lands on the edge where the master samples ack, never earlier,
  // so a master that drops the cycle before ack leaves no trace.
  assign wr_fire = bus_req && we_i && st_reg.ack && sel_i[0];

  // Status shows the sequencer, the lock input and the amplifier.
  always_comb begin
    status = 8'h00;
    status[rtxc_pkg::BIT_STAT_TX_ACTIVE] = (st_reg.fsm == rtxc_pkg::ST_TX);
    status[rtxc_pkg::BIT_STAT_LOCK] = synth_lock_i;
    status[rtxc_pkg::BIT_STAT_AMP] = st_reg.amp_on;
    status[rtxc_pkg::POS_STAT_STATE +: 4] = st_reg.fsm;
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    timer_start = 1'b0;

    // Ack follows a request by one cycle and drops right after.
    st_next.ack = bus_req && !st_reg.ack;

    // Read data is captured with the ack; unmapped words read as zero.
    if (bus_req && !st_reg.ack) begin
      case (reg_idx)
        rtxc_pkg::IDX_RADIO_CONTROL: begin
          st_next.rdata = st_reg.ctrl;
        end
        rtxc_pkg::IDX_CODE_WIDTH: begin
          st_next.rdata = st_reg.code_width;
        end
        rtxc_pkg::IDX_SETTLE_COUNT: begin
          st_next.rdata = st_reg.settle_count;
        end
        rtxc_pkg::IDX_STATUS: begin
          st_next.rdata = status;
        end
        default: begin
          st_next.rdata = 8'h00;
        end
      endcase
    end

    // Writes store the whole low byte; the reserved bits are kept as written
    // because firmware is expected to set them and may read them back.
    if (wr_fire) begin
      case (reg_idx)
        rtxc_pkg::IDX_RADIO_CONTROL: begin
          st_next.ctrl = dat_i[7:0];
        end
        rtxc_pkg::IDX_CODE_WIDTH: begin
          st_next.code_width = dat_i[7:0];
        end
        rtxc_pkg::IDX_SETTLE_COUNT: begin
          st_next.settle_count = dat_i[7:0];
        end
        default: begin
          st_next.rdata = st_reg.rdata;
        end
      endcase
    end

    // Transmit sequencer. Clearing transmit-on aborts from any state.
    case (st_reg.fsm)
      rtxc_pkg::ST_IDLE: begin
        if (tx_on) begin
          if (lock_bypass) begin
            st_next.fsm = rtxc_pkg::ST_SETTLE;
            timer_start = 1'b1;
          end else begin
            st_next.fsm = rtxc_pkg::ST_LOCK;
          end
        end
      end
      rtxc_pkg::ST_LOCK: begin
        if (!tx_on) begin
          st_next.fsm = rtxc_pkg::ST_IDLE;
        end else if (synth_lock_i) begin
          st_next.fsm = rtxc_pkg::ST_SETTLE;
          timer_start = 1'b1;
        end
      end
      rtxc_pkg::ST_SETTLE: begin
        if (!tx_on) begin
          st_next.fsm = rtxc_pkg::ST_IDLE;
        end else if (timer_done) begin
          st_next.fsm = rtxc_pkg::ST_TX;
        end
      end
      rtxc_pkg::ST_TX: begin
        if (!tx_on) begin
          st_next.fsm = rtxc_pkg::ST_IDLE;
        end
      end
      default: begin
        st_next.fsm = rtxc_pkg::ST_IDLE;
      end
    endcase

    // The half select only matters for 32-chip codes; otherwise the lower
    // half is reported so the correlator sees a stable choice.
    st_next.upper_half = code_32 && half_sel;

    // Manual mode drives the amplifier from the enable bit; otherwise the
    // sequencer turns it on only while transmitting.
    if (amp_manual_mode) begin
      st_next.amp_on = amp_manual_on;
    end else begin
      st_next.amp_on = (st_reg.fsm == rtxc_pkg::ST_TX);
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg.ctrl <= rtxc_pkg::RST_RADIO_CONTROL;
      st_reg.code_width <= rtxc_pkg::RST_CODE_WIDTH;
      st_reg.settle_count <= rtxc_pkg::RST_SETTLE_COUNT;
      st_reg.fsm <= rtxc_pkg::ST_IDLE;
      st_reg.ack <= 1'b0;
      st_reg.rdata <= 8'h00;
      st_reg.upper_half <= 1'b0;
      st_reg.amp_on <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Settle timer
  // ---------------------------------------------------------------------------
  // Loaded as the sequencer enters the settle state, so the count in use is
  // the one present at that moment; later writes do not stretch the wait.
  rtxc_settle_timer #(
    .UNIT_CYCLES(UNIT_CYCLES),
    .COUNT_W(8)
  ) u_settle_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(timer_start),
    .count_i(st_reg.settle_count),
    .done_o(timer_done)
  );

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign ack_o = st_reg.ack;
  assign dat_o = {24'h000000, st_reg.rdata};
  assign synth_enable_o = (st_reg.fsm != rtxc_pkg::ST_IDLE);
  assign tx_mode_o = (st_reg.fsm == rtxc_pkg::ST_TX);
  assign upper_half_o = st_reg.upper_half;
  assign amp_on_o = st_reg.amp_on;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_tx_off;
    @(posedge clk_i) disable iff (rst_i)
    !tx_on |=> !tx_mode_o;
  endproperty
  a_tx_off: assert property (p_tx_off)
    else $error("transmit mode active with transmit-on clear");

  property p_upper_half;
    @(posedge clk_i) disable iff (rst_i)
    (code_32 && half_sel) |=> upper_half_o;
  endproperty
  a_upper_half: assert property (p_upper_half)
    else $error("upper half not selected for 32-chip code");

  property p_half_ignored;
    @(posedge clk_i) disable iff (rst_i)
    !code_32 |=> !upper_half_o;
  endproperty
  a_half_ignored: assert property (p_half_ignored)
    else $error("half select acted without 32-chip codes");

  property p_bypass;
    @(posedge clk_i) disable iff (rst_i)
    (st_reg.fsm == rtxc_pkg::ST_IDLE && tx_on && lock_bypass)
      |=> (st_reg.fsm == rtxc_pkg::ST_SETTLE);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass did not go straight to settling");

  property p_wait_lock;
    @(posedge clk_i) disable iff (rst_i)
    (st_reg.fsm == rtxc_pkg::ST_LOCK && tx_on && !synth_lock_i)
      |=> (st_reg.fsm == rtxc_pkg::ST_LOCK) && !tx_mode_o;
  endproperty
  a_wait_lock: assert property (p_wait_lock)
    else $error("left lock wait without the lock indication");

  property p_manual_follow;
    @(posedge clk_i) disable iff (rst_i)
    amp_manual_mode |=> (amp_on_o == $past(amp_manual_on));
  endproperty
  a_manual_follow: assert property (p_manual_follow)
    else $error("amplifier did not follow the manual enable bit");

  property p_auto_amp;
    @(posedge clk_i) disable iff (rst_i)
    (!amp_manual_mode && st_reg.fsm != rtxc_pkg::ST_TX) |=> !amp_on_o;
  endproperty
  a_auto_amp: assert property (p_auto_amp)
    else $error("manual enable acted in automatic mode");

  property p_ctrl_write;
    @(posedge clk_i) disable iff (rst_i)
    (wr_fire && reg_idx == rtxc_pkg::IDX_RADIO_CONTROL)
      |=> (st_reg.ctrl == $past(dat_i[7:0])) ##1 ack_o == 1'b0;
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write not stored or ack held");

  // Lock seen while waiting moves on to the settle wait at the next edge.
  property p_lock_to_settle;
    @(posedge clk_i) disable iff (rst_i)
    (st_reg.fsm == rtxc_pkg::ST_LOCK && tx_on && synth_lock_i)
      |=> (st_reg.fsm == rtxc_pkg::ST_SETTLE);
  endproperty
  a_lock_to_settle: assert property (p_lock_to_settle)
    else $error("lock indication did not start the settle wait");

  // Transmit mode never shows before the settle timer has run out.
  property p_no_early_tx;
    @(posedge clk_i) disable iff (rst_i)
    (st_reg.fsm == rtxc_pkg::ST_SETTLE && !timer_done) |=> !tx_mode_o;
  endproperty
  a_no_early_tx: assert property (p_no_early_tx)
    else $error("transmit mode before the settle time passed");

  // An expired timer with transmit-on still set enters transmit mode.
  property p_settle_to_tx;
    @(posedge clk_i) disable iff (rst_i)
    (st_reg.fsm == rtxc_pkg::ST_SETTLE && tx_on && timer_done) |=> tx_mode_o;
  endproperty
  a_settle_to_tx: assert property (p_settle_to_tx)
    else $error("settle wait ended without transmit mode");

  // Manual mode with the enable bit set turns the amplifier on.
  property p_amp_manual_on;
    @(posedge clk_i) disable iff (rst_i)
    (amp_manual_mode && amp_manual_on) |=> amp_on_o;
  endproperty
  a_amp_manual_on: assert property (p_amp_manual_on)
    else $error("manual enable set but amplifier off");

  // Only a stored write to the control word may change it.
  property p_ctrl_hold;
    @(posedge clk_i) disable iff (rst_i)
    !(wr_fire && reg_idx == rtxc_pkg::IDX_RADIO_CONTROL) |=> $stable(st_reg.ctrl);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold)
    else $error("control word changed without a write");

  // Ack is a single-cycle pulse, so a master never sees a stale second ack.
  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held for more than one cycle");

endmodule

// ---- rtl/rtxc_pkg.sv ----
// Shared constants for the radio transmit control block.
// Assumes a 100 MHz system clock and a Wishbone slave with 32-bit data.
package rtxc_pkg;

  // ---------------------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [5:0] IDX_RADIO_CONTROL = 6'h03; // Transmit control fields.
  localparam logic [5:0] IDX_CODE_WIDTH = 6'h04; // Chips-per-bit setting.
  localparam logic [5:0] IDX_SETTLE_COUNT = 6'h38; // Settle time in 2 us units.
  localparam logic [5:0] IDX_STATUS = 6'h3f; // Read-only sequencer status.

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned BIT_TX_ON = 6; // Transmit mode request.
  localparam int unsigned BIT_HALF_SEL = 5; // Upper or lower half of the code.
  localparam int unsigned BIT_LOCK_BYPASS = 4; // Skip the lock indication.
  localparam int unsigned BIT_AMP_MANUAL_MODE = 3; // Register controls the amplifier.
  localparam int unsigned BIT_AMP_MANUAL_ON = 2; // Manual amplifier state.
  localparam int unsigned BIT_CODE_32 = 2; // In the code width register.
  localparam int unsigned BIT_STAT_TX_ACTIVE = 0; // Status: transmitting.
  localparam int unsigned BIT_STAT_LOCK = 1; // Status: lock input level.
  localparam int unsigned BIT_STAT_AMP = 2; // Status: amplifier on.
  localparam int unsigned POS_STAT_STATE = 4; // Status: one-hot state, four bits.

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_RADIO_CONTROL = 8'h00;
  localparam logic [7:0] RST_CODE_WIDTH = 8'h00;
  localparam logic [7:0] RST_SETTLE_COUNT = 8'h00;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10; // System clock period.
  localparam int unsigned SETTLE_UNIT_NS = 2000; // One settle-count unit.
  // A least time, so the cycle count rounds up.
  localparam int unsigned SETTLE_UNIT_CYCLES =
    (SETTLE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------------
  // Transmit sequencer states
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_LOCK = 4'h2,
    ST_SETTLE = 4'h4,
    ST_TX = 4'h8
  } rtxc_state_t;

endpackage

// ---- rtl/rtxc_settle_timer.sv ----
// Settle timer: counts a programmed number of fixed-length time units.
// Assumes start_i is a one-cycle pulse from the sequencer in the same clock.
`timescale 1ns/1ps
module rtxc_settle_timer #(
  parameter int unsigned UNIT_CYCLES = rtxc_pkg::SETTLE_UNIT_CYCLES,
  parameter int unsigned COUNT_W = 8
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Control.
  input wire logic start_i,
  input wire logic [COUNT_W-1:0] count_i,
  // Result.
  output logic done_o
);

  localparam int unsigned PRE_W = $clog2(UNIT_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(UNIT_CYCLES - 1);

  // Remaining units and the cycle prescaler inside the current unit.
  typedef struct packed {
    logic [COUNT_W-1:0] units;
    logic [PRE_W-1:0] pre;
  } rtxc_timer_state_t;

  rtxc_timer_state_t st_reg; // Registered state.
  rtxc_timer_state_t st_next; // Next state.

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // A unit ends when the prescaler reaches zero; a new start always wins.
  always_comb begin
    st_next = st_reg;
    if (start_i) begin
      st_next.units = count_i;
      st_next.pre = PRE_LAST;
    end else if (st_reg.units != '0) begin
      if (st_reg.pre == '0) begin
        st_next.units = st_reg.units - COUNT_W'(1);
        st_next.pre = PRE_LAST;
      end else begin
        st_next.pre = st_reg.pre - PRE_W'(1);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Done is a level while no units remain; a zero count finishes at once.
  assign done_o = (st_reg.units == '0);

  // Each unit lasts exactly UNIT_CYCLES clocks.
  property p_unit_step;
    @(posedge clk_i) disable iff (rst_i)
    (st_reg.units != '0 && st_reg.pre == '0 && !start_i)
      |=> (st_reg.units == $past(st_reg.units) - COUNT_W'(1)) && (st_reg.pre == PRE_LAST);
  endproperty
  a_unit_step: assert property (p_unit_step)
    else $error("settle unit did not end after its prescale");

endmodule

// ---- dv/rtxc_fw_model.sv ----
// Firmware model: a classic Wishbone master that programs the radio control block.
// Assumes it shares the block's clock and waits out the block's reset itself.
`timescale 1ns/1ps
module rtxc_fw_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone master side.
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o,
  input wire logic [31:0] dat_i,
  input wire logic ack_i
);
  // -------------------------------------------------------------------------
  // Bus idle from time zero.
  // -------------------------------------------------------------------------
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h00000000;
  end

  // One classic cycle, held until ack is sampled; the bench watchdog ends a hang.
  task automatic bus_cycle(input logic we, input logic [5:0] idx, input logic [3:0] sel,
      input logic [7:0] wdat, output logic [7:0] rdat);
    @(posedge clk_i);
    while (rst_i) begin
      @(posedge clk_i);
    end
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= we;
    adr_o <= {idx, 2'b00};
    sel_o <= sel;
    dat_o <= {24'h000000, wdat};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    rdat = dat_i[7:0];
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
  endtask

  // Register write; the control register always carries its reserved ones.
  task automatic fw_write(input logic [5:0] idx, input logic [7:0] val);
    logic [7:0] d;
    logic [7:0] r;
    d = val;
    if (idx == rtxc_pkg::IDX_RADIO_CONTROL) begin
      d = d | 8'h03;
    end
    bus_cycle(1'b1, idx, 4'h1, d, r);
  endtask

  // Register read of the low byte.
  task automatic fw_read(input logic [5:0] idx, output logic [7:0] val);
    bus_cycle(1'b0, idx, 4'hf, 8'h00, val);
  endtask
endmodule

// ---- dv/radio_tx_control_bits_test.sv ----
// Self-checking bench for the radio transmit control block.
// Assumes the firmware model drives the bus; the bench drives the lock input.
`timescale 1ns/1ps
module radio_tx_control_bits_test;
  // -------------------------------------------------------------------------
  // Signals and settings.
  // -------------------------------------------------------------------------
  localparam int U = 4; // Short settle unit keeps the run brief.
  typedef struct packed {
    logic [7:0] cw;
    logic [7:0] ctrl;
    logic up;
    logic amp;
  } rtxc_row_t;
  // Code width, control, expected upper half and amplifier with transmit off.
  localparam rtxc_row_t ROWS [6] = '{'{8'h04, 8'h20, 1'b1, 1'b0},
    '{8'h04, 8'h00, 1'b0, 1'b0}, '{8'h00, 8'h20, 1'b0, 1'b0},
    '{8'h00, 8'h0c, 1'b0, 1'b1}, '{8'h00, 8'h08, 1'b0, 1'b0},
    '{8'h00, 8'h04, 1'b0, 1'b0}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic synth_lock = 1'b0;
  logic cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic synth_enable, tx_mode, upper_half, amp_on;
  logic [7:0] rd;
  int errors = 0;
  int check_count = 0;

  always #5 clk = ~clk;

  rtxc_radio_tx_ctrl #(.ADR_W(8), .UNIT_CYCLES(U)) u_dut (.clk_i(clk), .rst_i(rst),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
    .dat_o(rdat), .ack_o(ack), .synth_lock_i(synth_lock), .synth_enable_o(synth_enable),
    .tx_mode_o(tx_mode), .upper_half_o(upper_half), .amp_on_o(amp_on));

  rtxc_fw_model u_fw (.clk_i(clk), .rst_i(rst), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));

  // -------------------------------------------------------------------------
  // Compare and closing tasks.
  // -------------------------------------------------------------------------
  task automatic check_bit(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_num(input string name, input int exp, input int got);
    check_count++;
    if (got != exp) begin
      errors++;
      $display("mismatch %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Counts edges until transmit mode shows; bounded so a stuck sequencer is caught.
  task automatic wait_tx(input int exp_edges);
    int k;
    k = 0;
    while (tx_mode !== 1'b1 && k < 1000) begin
      @(posedge clk);
      #1;
      k++;
    end
    check_num("edges to transmit", exp_edges, k);
  endtask

  // Lets settled outputs be looked at two edges after a stored write.
  task automatic settle2();
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Watchdog: the whole sequence takes well under 50000 cycles.
  initial begin
    #500000;
    errors++;
    tally_and_finish();
  end

  // -------------------------------------------------------------------------
  // Main sequence.
  // -------------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check_bit("tx after reset", 1'b0, tx_mode);
    check_bit("amp after reset", 1'b0, amp_on);
    u_fw.fw_read(rtxc_pkg::IDX_RADIO_CONTROL, rd);
    check_byte("control reset", rtxc_pkg::RST_RADIO_CONTROL, rd);
    u_fw.fw_read(rtxc_pkg::IDX_SETTLE_COUNT, rd);
    check_byte("settle reset", rtxc_pkg::RST_SETTLE_COUNT, rd);
    // Ordinary cases: field decoding with transmit off.
    for (int i = 0; i < 6; i++) begin
      u_fw.fw_write(rtxc_pkg::IDX_CODE_WIDTH, ROWS[i].cw);
      u_fw.fw_write(rtxc_pkg::IDX_RADIO_CONTROL, ROWS[i].ctrl);
      settle2();
      check_bit("upper half", ROWS[i].up, upper_half);
      check_bit("amp on", ROWS[i].amp, amp_on);
      u_fw.fw_read(rtxc_pkg::IDX_RADIO_CONTROL, rd);
      check_byte("control readback", ROWS[i].ctrl | 8'h03, rd);
      u_fw.fw_read(rtxc_pkg::IDX_CODE_WIDTH, rd);
      check_byte("code width readback", ROWS[i].cw, rd);
    end
    // A write without the low byte lane stores nothing.
    u_fw.bus_cycle(1'b1, rtxc_pkg::IDX_RADIO_CONTROL, 4'he, 8'h5a, rd);
    u_fw.fw_read(rtxc_pkg::IDX_RADIO_CONTROL, rd);
    check_byte("control kept", 8'h07, rd);
    // Unmapped index reads zero and keeps nothing.
    u_fw.fw_write(6'h10, 8'hff);
    u_fw.fw_read(6'h10, rd);
    check_byte("unmapped read", 8'h00, rd);
    // Bypass set: lock stays low, only the settle count is waited.
    u_fw.fw_write(rtxc_pkg::IDX_SETTLE_COUNT, 8'h02);
    u_fw.fw_write(rtxc_pkg::IDX_RADIO_CONTROL, 8'h50);
    wait_tx(2 * U + 2);
    settle2();
    check_bit("auto amp in transmit", 1'b1, amp_on);
    u_fw.fw_write(rtxc_pkg::IDX_RADIO_CONTROL, 8'h58);
    settle2();
    check_bit("manual amp off", 1'b0, amp_on);
    u_fw.fw_write(rtxc_pkg::IDX_RADIO_CONTROL, 8'h10);
    settle2();
    check_bit("tx cleared", 1'b0, tx_mode);
    check_bit("amp after clear", 1'b0, amp_on);
    // Bypass clear: hold in lock wait, then settle after lock rises.
    u_fw.fw_write(rtxc_pkg::IDX_SETTLE_COUNT, 8'h19);
    u_fw.fw_write(rtxc_pkg::IDX_RADIO_CONTROL, 8'h40);
    repeat (30) @(posedge clk);
    #1;
    check_bit("no tx before lock", 1'b0, tx_mode);
    check_bit("synth on in wait", 1'b1, synth_enable);
    @(posedge clk);
    synth_lock <= 1'b1;
    wait_tx(25 * U + 2);
    // Status in transmit: state one-hot 8, amplifier on, lock high, transmitting.
    u_fw.fw_read(rtxc_pkg::IDX_STATUS, rd);
    check_byte("status in transmit", 8'h87, rd);
    u_fw.fw_read(rtxc_pkg::IDX_SETTLE_COUNT, rd);
    check_byte("settle readback", 8'h19, rd);
    u_fw.fw_write(rtxc_pkg::IDX_RADIO_CONTROL, 8'h00);
    settle2();
    check_bit("idle synth off", 1'b0, synth_enable);
    // Reset in mid-settle: outputs and registers return to their reset values.
    u_fw.fw_write(rtxc_pkg::IDX_RADIO_CONTROL, 8'h50);
    settle2();
    check_bit("synth on before reset", 1'b1, synth_enable);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check_bit("synth after mid reset", 1'b0, synth_enable);
    check_bit("tx after mid reset", 1'b0, tx_mode);
    check_bit("amp after mid reset", 1'b0, amp_on);
    u_fw.fw_read(rtxc_pkg::IDX_RADIO_CONTROL, rd);
    check_byte("control after mid reset", rtxc_pkg::RST_RADIO_CONTROL, rd);
    u_fw.fw_read(rtxc_pkg::IDX_SETTLE_COUNT, rd);
    check_byte("settle after mid reset", rtxc_pkg::RST_SETTLE_COUNT, rd);
    tally_and_finish();
  end
endmodule
